// >>> hw/eeb_cfg.svh
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: 16-bit register port, byte-addressed, little-endian lanes.
// Notes: Summary of operation follows.
`ifndef EEB_CFG_SVH
`define EEB_CFG_SVH
// Register offsets (byte addresses).
`define EEB_OFF_STATUS 8'hE4
`define EEB_OFF_RECOV 8'hE6
`define EEB_OFF_BLOAD 8'hE7
// Status register field positions.
`define EEB_BIT_RX_LPI 10
`define EEB_BIT_RSV_HI 9
`define EEB_BIT_RSV_LO 8
`define EEB_BIT_LOC_ABLE 6
`define EEB_BIT_LOC_SEL 5
`define EEB_BIT_PD_FAULT 4
`define EEB_BIT_LP_NP 3
`define EEB_BIT_NP_ABLE 2
`define EEB_BIT_PAGE_RX 1
`define EEB_BIT_LP_AN 0
// Buffer load control field positions.
`define EEB_BIT_TRAF_EN 7
`define EEB_THR_MSB 5
// Reset values.
`define EEB_RST_RECOV 8'h27
`define EEB_RST_THR 6'h08
`define EEB_RST_RSV 2'h0
// Timing: one recovery count in ns, clock period in ns.
`define EEB_TICK_NS 640
`define EEB_CLK_NS 4
`define EEB_TICK_CYC (`EEB_TICK_NS / `EEB_CLK_NS)
// Buffer load unit in bytes, as a shift.
`define EEB_UNIT_SHIFT 9
`endif

// >>> hw/eeb_pkg.sv
// Purpose: Types shared by the LPI status and control bank.
// Assumes: Constants come from eeb_cfg.svh.
// Notes: One-hot recovery state codes.
package eeb_pkg;
    // Recovery sequencer states.
    typedef enum logic [2:0] {
        EEB_IDLE = 3'b001,
        EEB_LPI = 3'b010,
        EEB_RECOVER = 3'b100
    } eeb_state_t;
endpackage

// >>> hw/eeb_top.sv
// Purpose: Port 1 EEE status, auto-negotiation expansion and LPI control.
// Assumes: Inputs are synchronous to i_mclk; events are one-cycle pulses.
// Notes: Read data appears one cycle after the read strobe.
`timescale 1ns/1ps
`include "eeb_cfg.svh"
module eeb_top #(
    parameter int BUF_W = 16
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_rd,
    input wire logic i_reg_wr,
    input wire logic [1:0] i_reg_be,
    input wire logic [15:0] i_reg_wdata,
    input wire logic i_rx_lpi,
    input wire logic i_pd_fault,
    input wire logic i_page_rx,
    input wire logic i_lp_np_able,
    input wire logic i_lp_an_able,
    input wire logic i_tx_lpi,
    input wire logic i_lpi_req,
    input wire logic i_input_traffic,
    input wire logic [BUF_W-1:0] i_buf_used,
    output logic [15:0] o_reg_rdata,
    output logic o_tx_hold,
    output logic o_lpi_abort
);

    // Last tick index of a recovery count: cycles per count, from the tick time and clock period, less one.
    localparam logic [7:0] TICK_LAST = 8'(`EEB_TICK_CYC - 1);

    // Register state.
    logic [1:0] rsv_ff, nxt_rsv;
    logic pd_ff, nxt_pd;
    logic page_ff, nxt_page;
    logic [7:0] recov_ff, nxt_recov;
    logic traf_en_ff, nxt_traf_en;
    logic [5:0] thr_ff, nxt_thr;
    logic [15:0] rdata_ff, nxt_rdata;
    // Recovery sequencer state.
    eeb_pkg::eeb_state_t state_ff, nxt_state;
    logic [7:0] tick_ff, nxt_tick;
    logic [7:0] cnt_ff, nxt_cnt;
    logic hold_ff, nxt_hold;
    logic abort_ff, nxt_abort;
    // Checker helpers: cycles in the running hold and the count it started from.
    logic [15:0] run_ff, nxt_run;
    logic [7:0] len_ff, nxt_len;
    // Decoded strobes.
    logic rd_status;
    logic wr_status;
    logic wr_recov;
    logic wr_bload;
    logic over_thr;

    // Address match; one decoder serves reads and writes alike.
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // The recovery and load-control bytes share one 16-bit word.
    assign rd_status = i_reg_rd && hit(i_reg_addr, `EEB_OFF_STATUS);
    assign wr_status = i_reg_wr && hit(i_reg_addr, `EEB_OFF_STATUS) && i_reg_be[1];
    assign wr_recov = i_reg_wr && hit(i_reg_addr, `EEB_OFF_RECOV) && i_reg_be[0];
    assign wr_bload = i_reg_wr && hit(i_reg_addr, `EEB_OFF_RECOV) && i_reg_be[1];

    // Threshold is in 512-byte units, so widen it before comparing bytes.
    assign over_thr = ({{BUF_W{1'b0}}, i_buf_used}
        > ({{BUF_W{1'b0}}, 10'(thr_ff)} << `EEB_UNIT_SHIFT));

    // Next values of the software-visible registers.
    always_comb
    begin
        nxt_rsv = rsv_ff;
        nxt_recov = recov_ff;
        nxt_traf_en = traf_en_ff;
        nxt_thr = thr_ff;
        // Writable reserved bits only hold what software writes.
        if (wr_status)
        begin
            nxt_rsv = i_reg_wdata[`EEB_BIT_RSV_HI:`EEB_BIT_RSV_LO];
        end
        // Software should load the larger of both recovery times here.
        if (wr_recov)
        begin
            nxt_recov = i_reg_wdata[7:0];
        end
        // Bit 14 of the word is the read-only reserved bit; it is dropped.
        if (wr_bload)
        begin
            nxt_traf_en = i_reg_wdata[8 + `EEB_BIT_TRAF_EN];
            nxt_thr = i_reg_wdata[8 + `EEB_THR_MSB:8];
        end
        // A new event in the read cycle survives, so set beats clear.
        nxt_pd = (pd_ff && !rd_status) || i_pd_fault;
        nxt_page = (page_ff && !rd_status) || i_page_rx;
    end

    // Registers for the software-visible fields.
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rsv_ff <= `EEB_RST_RSV;
            pd_ff <= 1'b0;
            page_ff <= 1'b0;
            recov_ff <= `EEB_RST_RECOV;
            traf_en_ff <= 1'b0;
            thr_ff <= `EEB_RST_THR;
        end
        else
        begin
            rsv_ff <= nxt_rsv;
            pd_ff <= nxt_pd;
            page_ff <= nxt_page;
            recov_ff <= nxt_recov;
            traf_en_ff <= nxt_traf_en;
            thr_ff <= nxt_thr;
        end
    end

    // Read mux; unmapped addresses read zero and data is held otherwise.
    always_comb
    begin
        nxt_rdata = rdata_ff;
        if (i_reg_rd)
        begin
            nxt_rdata = 16'h0000;
            if (hit(i_reg_addr, `EEB_OFF_STATUS))
            begin
                nxt_rdata[`EEB_BIT_RX_LPI] = i_rx_lpi;
                nxt_rdata[`EEB_BIT_RSV_HI:`EEB_BIT_RSV_LO] = rsv_ff;
                nxt_rdata[`EEB_BIT_LOC_ABLE] = 1'b1;
                nxt_rdata[`EEB_BIT_LOC_SEL] = 1'b1;
                // Pending event is reported in the same read that clears it.
                nxt_rdata[`EEB_BIT_PD_FAULT] = pd_ff || i_pd_fault;
                nxt_rdata[`EEB_BIT_LP_NP] = i_lp_np_able;
                nxt_rdata[`EEB_BIT_NP_ABLE] = 1'b1;
                nxt_rdata[`EEB_BIT_PAGE_RX] = page_ff || i_page_rx;
                nxt_rdata[`EEB_BIT_LP_AN] = i_lp_an_able;
            end
            else if (hit(i_reg_addr, `EEB_OFF_RECOV))
            begin
                nxt_rdata = {traf_en_ff, 1'b0, thr_ff, recov_ff};
            end
        end
    end

    // Read data register.
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rdata_ff <= 16'h0000;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
        end
    end

    // Recovery sequencer: on leaving transmit LPI, hold the MAC for the
    // programmed number of 640 ns counts. The tick restarts at the exit so
    // the first count is never short.
    always_comb
    begin
        nxt_state = state_ff;
        nxt_tick = tick_ff;
        nxt_cnt = cnt_ff;
        unique case (state_ff)
            eeb_pkg::EEB_IDLE:
            begin
                if (i_tx_lpi)
                begin
                    nxt_state = eeb_pkg::EEB_LPI;
                end
            end
            eeb_pkg::EEB_LPI:
            begin
                if (!i_tx_lpi)
                begin
                    nxt_tick = 8'h00;
                    nxt_cnt = recov_ff;
                    // A zero wait means the MAC may send at once.
                    nxt_state = (recov_ff == 8'h00) ? eeb_pkg::EEB_IDLE
                        : eeb_pkg::EEB_RECOVER;
                end
            end
            eeb_pkg::EEB_RECOVER:
            begin
                // Re-entering LPI mid-wait abandons the countdown.
                if (i_tx_lpi)
                begin
                    nxt_state = eeb_pkg::EEB_LPI;
                end
                else if (tick_ff == TICK_LAST)
                begin
                    nxt_tick = 8'h00;
                    nxt_cnt = cnt_ff - 8'h01;
                    if (cnt_ff == 8'h01)
                    begin
                        nxt_state = eeb_pkg::EEB_IDLE;
                    end
                end
                else
                begin
                    nxt_tick = tick_ff + 8'h01;
                end
            end
            default:
            begin
                nxt_state = eeb_pkg::EEB_IDLE;
            end
        endcase
        nxt_hold = (nxt_state == eeb_pkg::EEB_RECOVER);
        // Abort only while a request is actually active.
        nxt_abort = i_lpi_req && ((traf_en_ff && i_input_traffic)
            || over_thr);
        // Only the hold-length check reads these, so synthesis may trim them.
        nxt_run = hold_ff ? run_ff + 16'h0001 : 16'h0000;
        nxt_len = (state_ff == eeb_pkg::EEB_LPI && !i_tx_lpi) ? recov_ff : len_ff;
    end

    // Sequencer and output registers.
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_ff <= eeb_pkg::EEB_IDLE;
            tick_ff <= 8'h00;
            cnt_ff <= 8'h00;
            hold_ff <= 1'b0;
            abort_ff <= 1'b0;
            run_ff <= 16'h0000;
            len_ff <= 8'h00;
        end
        else
        begin
            state_ff <= nxt_state;
            tick_ff <= nxt_tick;
            cnt_ff <= nxt_cnt;
            hold_ff <= nxt_hold;
            abort_ff <= nxt_abort;
            run_ff <= nxt_run;
            len_ff <= nxt_len;
        end
    end

    assign o_reg_rdata = rdata_ff;
    assign o_tx_hold = hold_ff;
    assign o_lpi_abort = abort_ff;

    // Checks on the status word as seen by a read, then on the recovery hold and the abort output.
    property p_rx_lpi;
        @(posedge i_mclk) disable iff (!i_rst_n)
        rd_status |=> o_reg_rdata[10] == $past(i_rx_lpi);
    endproperty
    a_rx_lpi: assert property (p_rx_lpi) else $error("rx lpi bit wrong");

    property p_const_bits;
        @(posedge i_mclk) disable iff (!i_rst_n)
        rd_status |=> o_reg_rdata[6] && o_reg_rdata[5];
    endproperty
    a_const_bits: assert property (p_const_bits) else $error("location bits wrong");

    property p_loc_sel;
        @(posedge i_mclk) disable iff (!i_rst_n)
        rd_status |=> o_reg_rdata[7:5] == 3'h3;
    endproperty
    a_loc_sel: assert property (p_loc_sel) else $error("store select wrong");

    property p_pd_fault;
        @(posedge i_mclk) disable iff (!i_rst_n)
        i_pd_fault ##1 rd_status |=> o_reg_rdata[4];
    endproperty
    a_pd_fault: assert property (p_pd_fault) else $error("fault latch wrong");

    property p_pd_clear;
        @(posedge i_mclk) disable iff (!i_rst_n)
        rd_status && !i_pd_fault |=> !pd_ff;
    endproperty
    a_pd_clear: assert property (p_pd_clear) else $error("fault not cleared");

    property p_lp_bits;
        @(posedge i_mclk) disable iff (!i_rst_n)
        rd_status |=> o_reg_rdata[3] == $past(i_lp_np_able)
            && o_reg_rdata[0] == $past(i_lp_an_able);
    endproperty
    a_lp_bits: assert property (p_lp_bits) else $error("partner bits wrong");

    property p_np_able;
        @(posedge i_mclk) disable iff (!i_rst_n)
        rd_status |=> o_reg_rdata[2];
    endproperty
    a_np_able: assert property (p_np_able) else $error("next page able wrong");

    property p_page_hold;
        @(posedge i_mclk) disable iff (!i_rst_n)
        i_page_rx ##1 !rd_status[*3] |=> page_ff;
    endproperty
    a_page_hold: assert property (p_page_hold) else $error("page latch lost");

    property p_an_able;
        @(posedge i_mclk) disable iff (!i_rst_n)
        rd_status && i_lp_an_able |=> o_reg_rdata[0];
    endproperty
    a_an_able: assert property (p_an_able) else $error("an able bit wrong");

    property p_recov_load;
        @(posedge i_mclk) disable iff (!i_rst_n)
        state_ff == eeb_pkg::EEB_LPI && !i_tx_lpi && recov_ff != 8'h00
            |=> cnt_ff == $past(recov_ff) && o_tx_hold;
    endproperty
    a_recov_load: assert property (p_recov_load) else $error("recovery not loaded");

    property p_tick_len;
        @(posedge i_mclk) disable iff (!i_rst_n)
        $fell(o_tx_hold) && !$past(i_tx_lpi)
            |-> run_ff == 16'(len_ff) * 16'(`EEB_TICK_CYC);
    endproperty
    a_tick_len: assert property (p_tick_len) else $error("tick length wrong");

    property p_traf_abort;
        @(posedge i_mclk) disable iff (!i_rst_n)
        i_lpi_req && i_input_traffic |=> o_lpi_abort == ($past(traf_en_ff) || $past(over_thr));
    endproperty
    a_traf_abort: assert property (p_traf_abort) else $error("traffic abort wrong");

    property p_buf_abort;
        @(posedge i_mclk) disable iff (!i_rst_n)
        i_lpi_req && over_thr |=> o_lpi_abort;
    endproperty
    a_buf_abort: assert property (p_buf_abort) else $error("buffer abort missing");

endmodule

// >>> sim/eeb_partner.sv
// Purpose: Behavioural model of the remote link partner across the port.
// Assumes: Bench commands are synchronous to i_mclk.
// Notes: Outputs are registered, so a command shows one cycle later.
`timescale 1ns/1ps
module eeb_partner (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_quiet,
    input wire logic i_page_go,
    input wire logic i_fault_go,
    input wire logic i_np,
    input wire logic i_an,
    output logic o_rx_lpi,
    output logic o_page_rx,
    output logic o_pd_fault,
    output logic o_lp_np_able,
    output logic o_lp_an_able
);
    // Line status changes only just after an edge, as a real receiver would report it.
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_rx_lpi <= 1'h0;
            o_page_rx <= 1'h0;
            o_pd_fault <= 1'h0;
            o_lp_np_able <= 1'h0;
            o_lp_an_able <= 1'h0;
        end
        else
        begin
            o_rx_lpi <= i_quiet;
            o_page_rx <= i_page_go;
            o_pd_fault <= i_fault_go;
            o_lp_np_able <= i_np;
            o_lp_an_able <= i_an;
        end
    end
endmodule

// >>> sim/tb_top.sv
// Purpose: Self-checking bench for the LPI status and control bank.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes: Random values come from an 8-bit shift register seeded with 57.
`timescale 1ns/1ps
`include "eeb_cfg.svh"
module tb_top;
    logic i_mclk, i_rst_n, i_reg_rd, i_reg_wr, i_tx_lpi, i_lpi_req, i_input_traffic;
    logic [7:0] i_reg_addr, seed, r;
    logic [1:0] i_reg_be, rsv;
    logic [15:0] i_reg_wdata, i_buf_used, o_reg_rdata, rd;
    logic i_rx_lpi, i_pd_fault, i_page_rx, i_lp_np_able, i_lp_an_able, o_tx_hold, o_lpi_abort;
    logic quiet, page_go, fault_go, np, an, en, tr;
    int error_cnt, total_checks, cyc, k;
    eeb_top #(.BUF_W(16)) eeb_top_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
        .i_reg_addr(i_reg_addr), .i_reg_rd(i_reg_rd), .i_reg_wr(i_reg_wr),
        .i_reg_be(i_reg_be), .i_reg_wdata(i_reg_wdata), .i_rx_lpi(i_rx_lpi),
        .i_pd_fault(i_pd_fault), .i_page_rx(i_page_rx), .i_lp_np_able(i_lp_np_able),
        .i_lp_an_able(i_lp_an_able), .i_tx_lpi(i_tx_lpi), .i_lpi_req(i_lpi_req),
        .i_input_traffic(i_input_traffic), .i_buf_used(i_buf_used),
        .o_reg_rdata(o_reg_rdata), .o_tx_hold(o_tx_hold), .o_lpi_abort(o_lpi_abort));
    eeb_partner eeb_partner_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_quiet(quiet),
        .i_page_go(page_go), .i_fault_go(fault_go), .i_np(np), .i_an(an),
        .o_rx_lpi(i_rx_lpi), .o_page_rx(i_page_rx), .o_pd_fault(i_pd_fault),
        .o_lp_np_able(i_lp_np_able), .o_lp_an_able(i_lp_an_able));
    // Free-running 250 MHz clock.
    initial
    begin
        i_mclk = 1'h0;
        forever #2 i_mclk = ~i_mclk;
    end
    // Next value of the random source.
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // Expected status word; constant bits are written out so a stuck bit shows.
    function automatic logic [15:0] exp_st(input logic rx, input logic [1:0] rv,
        input logic f, input logic n, input logic pg, input logic a);
        return {5'h00, rx, rv, 1'h0, 1'h1, 1'h1, f, n, 1'h1, pg, a};
    endfunction
    // Counts every comparison and reports a mismatch at once.
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Read: strobe for one edge, data is settled one cycle later.
    task automatic reg_rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge i_mclk);
        #1;
        i_reg_addr = a;
        i_reg_rd = 1'h1;
        @(posedge i_mclk);
        #1;
        i_reg_rd = 1'h0;
        d = o_reg_rdata;
    endtask
    // Write: strobe for one edge with enables and data held.
    task automatic reg_wr(input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
        @(posedge i_mclk);
        #1;
        i_reg_addr = a;
        i_reg_be = be;
        i_reg_wdata = d;
        i_reg_wr = 1'h1;
        @(posedge i_mclk);
        #1;
        i_reg_wr = 1'h0;
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Hang guard; the tests need about 1500 cycles.
    always @(posedge i_mclk)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            error_cnt++;
            $display("timeout");
            results();
        end
    end
    // Main sequence.
    initial
    begin
        {i_rst_n, i_reg_rd, i_reg_wr, i_tx_lpi, i_lpi_req, i_input_traffic} = 6'h00;
        {i_reg_addr, i_reg_be, i_reg_wdata, i_buf_used} = 42'h0;
        {quiet, page_go, fault_go, np, an} = 5'h00;
        seed = 8'h39;
        rsv = 2'h0;
        repeat (6) @(posedge i_mclk);
        #1;
        i_rst_n = 1'h1;
        reg_rd(8'hE4, rd);
        chk("status reset", exp_st(0, 0, 0, 0, 0, 0), rd);
        reg_rd(`EEB_OFF_RECOV, rd);
        chk("recovery word reset", 16'h0827, rd);
        reg_rd(8'h40, rd);
        chk("unmapped read", 16'h0000, rd);
        $display("test reset done");
        // Live partner bits and reserved bits, with random byte enables.
        for (int i = 0; i < 8; i++)
        begin
            seed = lfsr(seed);
            {quiet, np, an} = seed[2:0];
            reg_wr(8'hE4, seed[4:3], {seed, seed});
            if (seed[4])
                rsv = seed[1:0];
            reg_rd(8'hE4, rd);
            chk("status live", exp_st(quiet, rsv, 0, np, 0, an), rd);
        end
        $display("test live done");
        // Latched events report once, then clear on read.
        page_go = 1'h1;
        fault_go = 1'h1;
        @(posedge i_mclk);
        #1;
        {page_go, fault_go} = 2'h0;
        reg_rd(8'hE4, rd);
        chk("status latched", exp_st(quiet, rsv, 1, np, 1, an), rd);
        reg_rd(8'hE4, rd);
        chk("status cleared", exp_st(quiet, rsv, 0, np, 0, an), rd);
        $display("test latch done");
        // Full write shows the always-zero bit; the undecoded byte address is ignored.
        reg_wr(8'hE6, 2'h3, 16'hFFFF);
        reg_wr(8'hE7, 2'h3, 16'h0000);
        reg_rd(8'hE6, rd);
        chk("recovery word rw", 16'hBFFF, rd);
        $display("test rw done");
        // Hold after leaving transmit LPI; the value stands for the larger recovery time.
        for (int j = 0; j < 2; j++)
        begin
            r = (j == 0) ? 8'h02 : 8'h00;
            reg_wr(8'hE6, 2'h1, {8'h00, r});
            i_tx_lpi = 1'h1;
            repeat (2) @(posedge i_mclk);
            #1;
            i_tx_lpi = 1'h0;
            @(posedge i_mclk);
            #1;
            k = 0;
            for (int c = 0; c < 700; c++)
            begin
                if (o_tx_hold === 1'h1)
                    k++;
                @(posedge i_mclk);
                #1;
            end
            chk("hold cycles", 16'(r * `EEB_TICK_CYC), 16'(k));
        end
        $display("test recovery done");
        // Abort policy around the threshold boundary.
        for (int i = 0; i < 16; i++)
        begin
            seed = lfsr(seed);
            en = seed[7] & (i != 0);
            reg_wr(8'hE6, 2'h2, {en, 1'h0, seed[5:0], 8'h00});
            r = seed;
            seed = lfsr(seed);
            tr = seed[3] | (i < 2);
            i_lpi_req = seed[0] | (i < 3);
            i_input_traffic = tr;
            i_buf_used = {1'h0, r[5:0], 9'h000} + 16'(seed[2:1]) - 16'h0001;
            @(posedge i_mclk);
            #1;
            chk("abort", 16'(i_lpi_req & ((en & tr) | (i_buf_used > {1'h0, r[5:0], 9'h000}))),
                16'(o_lpi_abort));
        end
        $display("test abort done");
        results();
    end
endmodule
